// ### common/mrsd_pkg.sv
// What this block does
// - Keep app retry count 0..6, default 0
// - Broadcast one copy, else count plus two
// - Retries on: flag asks receiver for ack
// - No ack in 200 ms: resend after jitter
// - Up to four MAC sends per attempt
// - No app retries for purged indirect messages
// - Min backoff exponent 0..3; zero skips the first delay
// - Clear channel sends; busy backs off, then drops
// - Discovery broadcast carries optional name
// - Discovery timeout 0x1..0xFC, default 0x19, sent
// - Replies after discovery end are discarded
// - Option bit 1 adds own reply entry
// - Each reply reports signal strength magnitude
// - Leave command mode on success, stay on error
// - Resolution errors on timeout or empty name
// - Request type 0x08 answers with type 0x88
// - Channel mask default 0x1FFE, bit n is 0x0B+n
// - Mask governs every active and energy scan
// - Scan time: channels times 2^exp times 15.36ms
// - Coordinator startup scans only for allowed reassignments
// - Role select: 0 end device, 1 coordinator
// - No vendor header disables unicast app retries and discovery
package mrsd_pkg;
  // Clock and timer base
  localparam int CLK_MHZ = 250;
  localparam int TICK_US = 10;
  localparam int TICK_CYC = CLK_MHZ * TICK_US;
  localparam int ACK_WAIT_MS = 200;
  localparam int ACK_WAIT_TICKS = ACK_WAIT_MS * 1000 / TICK_US;
  localparam int JITTER_MS = 48;
  localparam int JITTER_TICKS = JITTER_MS * 1000 / TICK_US;
  localparam int DISC_UNIT_MS = 100;
  localparam int DISC_UNIT_TICKS = DISC_UNIT_MS * 1000 / TICK_US;
  localparam int SCAN_UNIT_NS = 15360000;
  localparam int SCAN_UNIT_TICKS = SCAN_UNIT_NS / (TICK_US * 1000);
  localparam int BACKOFF_US = 320;
  localparam int BACKOFF_TICKS = BACKOFF_US / TICK_US;
  // Retry and access limits
  localparam logic [2:0] RETRY_MAX = 3'h6;
  localparam logic [2:0] MAC_TRIES = 3'h4;
  localparam logic [2:0] BE_CAP = 3'h5;
  localparam logic [2:0] CSMA_TRIES = 3'h4;
  // Discovery and resolution
  localparam logic [7:0] DTO_MIN = 8'h01;
  localparam logic [7:0] DTO_MAX = 8'hFC;
  localparam int OPT_SELF_BIT = 1;
  localparam logic [7:0] FT_CMD_REQ = 8'h08;
  localparam logic [7:0] FT_CMD_RESP = 8'h88;
  localparam logic [15:0] SHORT_NONE = 16'hFFFF;
  // Scan
  localparam logic [4:0] CHAN_BASE = 5'h0B;
  localparam logic [3:0] CHAN_LAST = 4'hF;
  // Header modes
  localparam logic [1:0] HM_VENDOR = 2'h0;
  localparam logic [1:0] HM_PLAIN_ACK = 2'h2;
  localparam logic [1:0] HM_VENDOR_NOACK = 2'h3;

  // Settings held by the block
  typedef struct packed {
    logic [2:0] retry;
    logic [1:0] be;
    logic [7:0] dto;
    logic [7:0] opts;
    logic [15:0] mask;
    logic [3:0] sd;
    logic coord;
    logic pan_re;
    logic ch_re;
    logic [1:0] hm;
  } mrsd_cfg_type;
  localparam mrsd_cfg_type CFG_RST = '{3'h0, 2'h0, 8'h19, 8'h00,
    16'h1FFE, 4'h4, 1'b0, 1'b0, 1'b0, 2'h0};

  // Discovery reply as received; rssi is signed dBm
  typedef struct packed {
    logic [63:0] ext_addr;
    logic [15:0] short_addr;
    logic [7:0] rssi;
  } mrsd_reply_type;

  // Discovery report entry
  typedef struct packed {
    logic [31:0] high;
    logic [31:0] low;
    logic [7:0] strength;
  } mrsd_report_type;
endpackage

// ### hw/mrsd_timer.sv
`timescale 1ns/10ps
`default_nettype none
module mrsd_timer #(
  parameter int W = 26
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // Control
  input wire logic tick_in,
  input wire logic load_in,
  input wire logic [W-1:0] value_in,
  // Status
  output logic expired_out
);
  logic [W-1:0] cnt_ff; // Ticks left
  logic run_ff; // Armed

  // Load wins over the running count
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_ff <= '0;
      run_ff <= 1'b0;
    end else if (load_in) begin
      cnt_ff <= value_in;
      run_ff <= 1'b1;
    end else if (expired_out) begin
      run_ff <= 1'b0;
    end else if (run_ff && tick_in) begin
      cnt_ff <= cnt_ff - 1'b1;
    end
  end

  // One-cycle pulse when the count is used up
  assign expired_out = run_ff && (cnt_ff == '0);
endmodule // mrsd_timer
`default_nettype wire

// ### hw/mrsd_lfsr.sv
`timescale 1ns/10ps
`default_nettype none
module mrsd_lfsr #(
  parameter logic [15:0] SEED = 16'hACE1
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // Random word
  output logic [15:0] value_out
);
  logic [15:0] q_ff; // Shift state, never all zero
  wire fb = q_ff[15] ^ q_ff[13] ^ q_ff[12] ^ q_ff[10];

  // Free-running maximal-length shift
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      q_ff <= SEED;
    end else begin
      q_ff <= {q_ff[14:0], fb};
    end
  end

  assign value_out = q_ff;
endmodule // mrsd_lfsr
`default_nettype wire

// ### hw/mrsd_top.sv
`timescale 1ns/10ps
`default_nettype none
module mrsd_top
  import mrsd_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // Settings
  input wire logic cfg_we_in,
  input wire mrsd_cfg_type cfg_in,
  output mrsd_cfg_type cfg_out,
  // Transmit request
  input wire logic tx_req_in,
  input wire logic tx_bcast_in,
  input wire logic tx_purged_in,
  output logic tx_busy_out,
  output logic tx_done_out,
  output logic tx_ok_out,
  // MAC and radio
  input wire logic cca_clear_in,
  input wire logic mac_done_in,
  input wire logic mac_acked_in,
  input wire logic app_ack_in,
  output logic mac_send_out,
  output logic ack_request_out,
  // Discovery and name resolution
  input wire logic discover_nodes_in,
  input wire logic resolve_node_name_in,
  input wire logic [7:0] frame_type_in,
  input wire logic [4:0] name_len_in,
  input wire mrsd_reply_type self_in,
  input wire logic reply_valid_in,
  input wire mrsd_reply_type reply_in,
  output logic disc_req_out,
  output logic [7:0] disc_timeout_out,
  output logic disc_named_out,
  output logic report_valid_out,
  output mrsd_report_type report_out,
  output logic disc_busy_out,
  output logic disc_done_out,
  output logic resp_valid_out,
  output logic resp_ok_out,
  output logic [7:0] resp_frame_type_out,
  output logic cmd_mode_exit_out,
  output logic [31:0] dest_addr_high_out,
  output logic [31:0] dest_addr_low_out,
  // Scans
  input wire logic active_scan_cmd_in,
  input wire logic energy_scan_cmd_in,
  input wire logic assoc_start_in,
  input wire logic coord_start_in,
  output logic scan_busy_out,
  output logic scan_energy_out,
  output logic scan_dwell_out,
  output logic [4:0] scan_channel_out,
  output logic scan_done_out
);
  localparam int TW = 26; // Wide enough for the longest scan dwell

  ////////////////////////////////////////////////////////////////////
  // Tick prescaler and random source
  logic [11:0] pre_ff; // Cycle count within one tick
  logic tick_ff; // One pulse per tick
  logic [15:0] rnd; // Random word
  wire pre_wrap = (pre_ff == 12'(TICK_CYCLES - 1));

  // All slow timers share this tick to save counter width
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      pre_ff <= 12'h000;
      tick_ff <= 1'b0;
    end else begin
      pre_ff <= pre_wrap ? 12'h000 : pre_ff + 12'h001;
      tick_ff <= pre_wrap;
    end
  end

  mrsd_lfsr #(.SEED(16'hACE1)) u_rnd (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .value_out(rnd)
  );

  ////////////////////////////////////////////////////////////////////
  // Settings
  mrsd_cfg_type cfg_ff; // Held settings
  mrsd_cfg_type nxt_cfg; // Clamped write value

  // Out-of-range writes are clamped to the nearest legal value
  always_comb begin
    nxt_cfg = cfg_in;
    if (cfg_in.retry > RETRY_MAX) begin
      nxt_cfg.retry = RETRY_MAX;
    end
    if (cfg_in.dto < DTO_MIN) begin
      nxt_cfg.dto = DTO_MIN;
    end else if (cfg_in.dto > DTO_MAX) begin
      nxt_cfg.dto = DTO_MAX;
    end
  end

  // Reset gives the documented defaults
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      cfg_ff <= CFG_RST;
    end else if (cfg_we_in) begin
      cfg_ff <= nxt_cfg;
    end
  end

  assign cfg_out = cfg_ff;
  wire vendor_hdr = (cfg_ff.hm == HM_VENDOR) || (cfg_ff.hm == HM_VENDOR_NOACK);
  wire mac_rty_ok = (cfg_ff.hm == HM_VENDOR) || (cfg_ff.hm == HM_PLAIN_ACK);

  ////////////////////////////////////////////////////////////////////
  // Transmit retry and channel access
  typedef enum logic [7:0] {
    TX_IDLE = 8'h01,
    TX_ARM = 8'h02,
    TX_BACKOFF = 8'h04,
    TX_CCA = 8'h08,
    TX_SEND = 8'h10,
    TX_MACWAIT = 8'h20,
    TX_ACKWAIT = 8'h40,
    TX_JITTER = 8'h80
  } mrsd_tx_type;

  mrsd_tx_type tx_st_ff, nxt_tx; // Transmit state
  logic [2:0] left_ff, nxt_left; // App attempts still allowed
  logic [2:0] mtry_ff, nxt_mtry; // MAC sends done in attempt
  logic [2:0] csma_ff, nxt_csma; // Busy channel checks
  logic [2:0] be_ff, nxt_be; // Current backoff exponent
  logic bcast_ff, nxt_bcast; // Frame is a broadcast
  logic ackreq_ff, nxt_ackreq; // Ask receiver for an ack
  logic send, fin, fin_ok, tload; // Step strobes
  logic [TW-1:0] tval; // Timer load value
  logic t_exp; // Transmit timer done
  logic cca_s1_ff, cca_s2_ff; // Channel-clear synchroniser

  // Channel-clear comes from the radio front end
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      cca_s1_ff <= 1'b0;
      cca_s2_ff <= 1'b0;
    end else begin
      cca_s1_ff <= cca_clear_in;
      cca_s2_ff <= cca_s1_ff;
    end
  end

  // Attempt sizing and random delays
  wire uc_rty = vendor_hdr && !tx_purged_in;
  wire [2:0] bc_extra = (cfg_ff.retry == 3'h0) ? 3'h0 : cfg_ff.retry + 3'h1;
  wire [2:0] uc_extra = uc_rty ? cfg_ff.retry : 3'h0;
  wire [2:0] mac_lim = mac_rty_ok ? MAC_TRIES : 3'h1;
  wire [2:0] be_min = {1'b0, cfg_ff.be};
  wire [4:0] bo_mask = 5'((6'h01 << be_ff) - 6'h01);
  wire [4:0] bo_slots = rnd[4:0] & bo_mask;
  wire [TW-1:0] bo_val = TW'(bo_slots) * TW'(BACKOFF_TICKS);
  wire [12:0] jit_raw = rnd[12:0];
  wire [12:0] jit_lim = 13'(JITTER_TICKS);
  wire [12:0] jit = (jit_raw > jit_lim) ? jit_raw - jit_lim : jit_raw;
  wire acked = bcast_ff || mac_acked_in;

  // Next-state logic; counters follow the state
  always_comb begin
    nxt_tx = tx_st_ff;
    nxt_left = left_ff;
    nxt_mtry = mtry_ff;
    nxt_csma = csma_ff;
    nxt_be = be_ff;
    nxt_bcast = bcast_ff;
    nxt_ackreq = ackreq_ff;
    send = 1'b0;
    fin = 1'b0;
    fin_ok = 1'b0;
    tload = 1'b0;
    tval = bo_val;
    case (tx_st_ff)
      TX_IDLE: begin
        if (tx_req_in) begin
          nxt_bcast = tx_bcast_in;
          nxt_left = tx_bcast_in ? bc_extra : uc_extra;
          nxt_ackreq = !tx_bcast_in && (uc_extra != 3'h0);
          nxt_mtry = 3'h0;
          nxt_csma = 3'h0;
          nxt_be = be_min;
          nxt_tx = TX_ARM;
        end
      end
      TX_ARM: begin
        // Exponent zero skips the first delay entirely
        if (be_ff == 3'h0) begin
          nxt_tx = TX_CCA;
        end else begin
          tload = 1'b1;
          nxt_tx = TX_BACKOFF;
        end
      end
      TX_BACKOFF: begin
        if (t_exp) begin
          nxt_tx = TX_CCA;
        end
      end
      TX_CCA: begin
        if (cca_s2_ff) begin
          nxt_tx = TX_SEND;
        end else if (csma_ff == CSMA_TRIES - 3'h1) begin
          fin = 1'b1;
          nxt_tx = TX_IDLE;
        end else begin
          nxt_csma = csma_ff + 3'h1;
          nxt_be = (be_ff == BE_CAP) ? BE_CAP : be_ff + 3'h1;
          nxt_tx = TX_ARM;
        end
      end
      TX_SEND: begin
        send = 1'b1;
        nxt_tx = TX_MACWAIT;
      end
      TX_MACWAIT: begin
        if (mac_done_in) begin
          nxt_csma = 3'h0;
          nxt_be = be_min;
          if (!acked && (mtry_ff < mac_lim - 3'h1)) begin
            nxt_mtry = mtry_ff + 3'h1;
            nxt_tx = TX_ARM;
          end else if (!acked) begin
            if (left_ff != 3'h0) begin
              nxt_left = left_ff - 3'h1;
              tload = 1'b1;
              tval = TW'(jit);
              nxt_tx = TX_JITTER;
            end else begin
              fin = 1'b1;
              nxt_tx = TX_IDLE;
            end
          end else if (bcast_ff && (left_ff != 3'h0)) begin
            // Broadcast copies expect no acknowledgment
            nxt_left = left_ff - 3'h1;
            nxt_mtry = 3'h0;
            nxt_tx = TX_ARM;
          end else if (ackreq_ff) begin
            tload = 1'b1;
            tval = TW'(ACK_WAIT_TICKS);
            nxt_tx = TX_ACKWAIT;
          end else begin
            fin = 1'b1;
            fin_ok = 1'b1;
            nxt_tx = TX_IDLE;
          end
        end
      end
      TX_ACKWAIT: begin
        if (app_ack_in) begin
          fin = 1'b1;
          fin_ok = 1'b1;
          nxt_tx = TX_IDLE;
        end else if (t_exp && (left_ff != 3'h0)) begin
          nxt_left = left_ff - 3'h1;
          tload = 1'b1;
          tval = TW'(jit);
          nxt_tx = TX_JITTER;
        end else if (t_exp) begin
          fin = 1'b1;
          nxt_tx = TX_IDLE;
        end
      end
      TX_JITTER: begin
        if (t_exp) begin
          nxt_mtry = 3'h0;
          nxt_tx = TX_ARM;
        end
      end
      default: begin
        nxt_tx = TX_IDLE;
      end
    endcase
  end

  // Transmit registers
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      tx_st_ff <= TX_IDLE;
      left_ff <= 3'h0;
      mtry_ff <= 3'h0;
      csma_ff <= 3'h0;
      be_ff <= 3'h0;
      bcast_ff <= 1'b0;
      ackreq_ff <= 1'b0;
      mac_send_out <= 1'b0;
      tx_done_out <= 1'b0;
      tx_ok_out <= 1'b0;
    end else begin
      tx_st_ff <= nxt_tx;
      left_ff <= nxt_left;
      mtry_ff <= nxt_mtry;
      csma_ff <= nxt_csma;
      be_ff <= nxt_be;
      bcast_ff <= nxt_bcast;
      ackreq_ff <= nxt_ackreq;
      mac_send_out <= send;
      tx_done_out <= fin;
      tx_ok_out <= fin_ok;
    end
  end

  mrsd_timer #(.W(TW)) u_tx_tmr (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .tick_in(tick_ff),
    .load_in(tload),
    .value_in(tval),
    .expired_out(t_exp)
  );

  assign tx_busy_out = (tx_st_ff != TX_IDLE);
  assign ack_request_out = ackreq_ff && tx_busy_out;

  ////////////////////////////////////////////////////////////////////
  // Node discovery and name resolution
  logic d_run_ff; // Window open
  logic d_res_ff; // Operation is a resolution
  logic d_api_ff; // Resolution came as a command frame
  logic d_exp; // Window closed
  wire d_start = discover_nodes_in || resolve_node_name_in;
  wire d_go = !d_run_ff && d_start;
  wire d_api = (frame_type_in == FT_CMD_REQ);
  wire d_bad = !vendor_hdr || (resolve_node_name_in && (name_len_in == 5'h00));
  wire d_open = d_go && !d_bad;
  wire d_self = d_open && !resolve_node_name_in && cfg_ff.opts[OPT_SELF_BIT];
  wire d_hit = d_run_ff && reply_valid_in;
  wire d_res_ok = d_hit && d_res_ff;
  wire d_res_err = (d_go && d_bad && resolve_node_name_in) || (d_exp && d_run_ff && d_res_ff);
  wire d_end = d_res_ok || (d_exp && !d_res_ff) || (d_go && d_bad && !resolve_node_name_in);
  wire [TW-1:0] d_win = TW'(cfg_ff.dto) * TW'(DISC_UNIT_TICKS);
  mrsd_reply_type d_src; // Entry being reported
  assign d_src = d_self ? self_in : reply_in;
  wire d_short = (d_src.short_addr != SHORT_NONE);
  wire [31:0] d_high = d_short ? 32'h0000_0000 : d_src.ext_addr[63:32];
  wire [31:0] d_low = d_short ? {16'h0000, d_src.short_addr} : d_src.ext_addr[31:0];
  wire [7:0] d_mag = d_self ? 8'h00 : 8'h00 - d_src.rssi;

  // Operation state; replies outside a window are ignored
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      d_run_ff <= 1'b0;
      d_res_ff <= 1'b0;
      d_api_ff <= 1'b0;
    end else if (d_open) begin
      d_run_ff <= 1'b1;
      d_res_ff <= resolve_node_name_in;
      d_api_ff <= d_api;
    end else if (d_end || d_res_err) begin
      d_run_ff <= 1'b0;
    end
  end

  // Request broadcast and report outputs
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      disc_req_out <= 1'b0;
      disc_timeout_out <= 8'h00;
      disc_named_out <= 1'b0;
      report_valid_out <= 1'b0;
      report_out <= '0;
      disc_done_out <= 1'b0;
    end else begin
      disc_req_out <= d_open;
      disc_timeout_out <= d_open ? cfg_ff.dto : disc_timeout_out;
      disc_named_out <= d_open ? (name_len_in != 5'h00) : disc_named_out;
      report_valid_out <= d_self || (d_hit && !d_res_ff);
      report_out <= '{d_high, d_low, d_mag};
      disc_done_out <= d_end && !d_res_ok;
    end
  end

  // Resolution answer and destination update
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      resp_valid_out <= 1'b0;
      resp_ok_out <= 1'b0;
      resp_frame_type_out <= 8'h00;
      cmd_mode_exit_out <= 1'b0;
      dest_addr_high_out <= 32'h0000_0000;
      dest_addr_low_out <= 32'h0000_0000;
    end else begin
      resp_valid_out <= d_res_ok || d_res_err;
      resp_ok_out <= d_res_ok;
      resp_frame_type_out <= (d_run_ff ? d_api_ff : d_api) ? FT_CMD_RESP : 8'h00;
      cmd_mode_exit_out <= d_res_ok && !d_api_ff;
      if (d_res_ok && !d_api_ff) begin
        dest_addr_high_out <= d_high;
        dest_addr_low_out <= d_low;
      end
    end
  end

  mrsd_timer #(.W(TW)) u_d_tmr (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .tick_in(tick_ff),
    .load_in(d_open),
    .value_in(d_win),
    .expired_out(d_exp)
  );

  assign disc_busy_out = d_run_ff;

  ////////////////////////////////////////////////////////////////////
  // Channel scan
  typedef enum logic [2:0] {
    SC_IDLE = 3'h1,
    SC_PICK = 3'h2,
    SC_DWELL = 3'h4
  } mrsd_scan_type;

  mrsd_scan_type sc_st_ff; // Scan state
  logic [3:0] ch_ff; // Mask bit under test
  logic pend_ff; // Energy scan follows active scan
  logic s_exp; // Dwell over
  wire is_coord = cfg_ff.coord;
  wire cs_go = coord_start_in && is_coord;
  wire s_act = active_scan_cmd_in || (assoc_start_in && !is_coord) || (cs_go && cfg_ff.pan_re);
  wire s_en = energy_scan_cmd_in || (cs_go && !cfg_ff.pan_re && cfg_ff.ch_re);
  wire s_none = cs_go && !cfg_ff.pan_re && !cfg_ff.ch_re;
  wire s_idle = (sc_st_ff == SC_IDLE);
  wire s_on = cfg_ff.mask[ch_ff];
  wire s_last = (ch_ff == CHAN_LAST);
  wire s_step = ((sc_st_ff == SC_PICK) && !s_on) || ((sc_st_ff == SC_DWELL) && s_exp);
  wire s_load = (sc_st_ff == SC_PICK) && s_on;
  wire [TW-1:0] s_dwell = TW'(SCAN_UNIT_TICKS) << cfg_ff.sd;

  // Walks the mask one channel at a time, dwelling on enabled ones
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      sc_st_ff <= SC_IDLE;
      ch_ff <= 4'h0;
      pend_ff <= 1'b0;
      scan_energy_out <= 1'b0;
      scan_channel_out <= CHAN_BASE;
      scan_done_out <= 1'b0;
    end else begin
      scan_done_out <= 1'b0;
      case (sc_st_ff)
        SC_IDLE: begin
          ch_ff <= 4'h0;
          if (s_act || s_en) begin
            scan_energy_out <= !s_act;
            pend_ff <= cs_go && cfg_ff.pan_re && cfg_ff.ch_re;
            sc_st_ff <= SC_PICK;
          end else if (s_none) begin
            scan_done_out <= 1'b1;
          end
        end
        SC_PICK: begin
          if (s_on) begin
            scan_channel_out <= CHAN_BASE + 5'(ch_ff);
            sc_st_ff <= SC_DWELL;
          end
        end
        SC_DWELL: begin
          if (s_exp) begin
            sc_st_ff <= SC_PICK;
          end
        end
        default: begin
          sc_st_ff <= SC_IDLE;
        end
      endcase
      if (s_step && !s_last) begin
        ch_ff <= ch_ff + 4'h1;
      end else if (s_step && pend_ff) begin
        // Coordinator startup chains the energy scan
        pend_ff <= 1'b0;
        scan_energy_out <= 1'b1;
        ch_ff <= 4'h0;
        sc_st_ff <= SC_PICK;
      end else if (s_step) begin
        scan_done_out <= 1'b1;
        sc_st_ff <= SC_IDLE;
      end
    end
  end

  mrsd_timer #(.W(TW)) u_s_tmr (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .tick_in(tick_ff),
    .load_in(s_load),
    .value_in(s_dwell),
    .expired_out(s_exp)
  );

  assign scan_busy_out = !s_idle;
  assign scan_dwell_out = (sc_st_ff == SC_DWELL);
endmodule // mrsd_top
`default_nettype wire

// ### tb/mrsd_top_properties.sv
`timescale 1ns/10ps
`default_nettype none
module mrsd_top_properties
  import mrsd_pkg::*;
(
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // Settings and transmit
  input wire logic cfg_we_in,
  input wire mrsd_cfg_type cfg_in,
  input wire mrsd_cfg_type cfg_out,
  input wire logic tx_req_in,
  input wire logic tx_busy_out,
  input wire logic cca_clear_in,
  input wire logic mac_send_out,
  input wire logic ack_request_out,
  // Discovery and scan
  input wire logic resolve_node_name_in,
  input wire logic [4:0] name_len_in,
  input wire logic disc_busy_out,
  input wire logic disc_req_out,
  input wire logic [7:0] disc_timeout_out,
  input wire logic resp_valid_out,
  input wire logic resp_ok_out,
  input wire logic cmd_mode_exit_out,
  input wire logic scan_dwell_out,
  input wire logic [4:0] scan_channel_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  retry_clamp_a: assert property (cfg_we_in && cfg_in.retry > 3'h6 |=> cfg_out.retry == 3'h6)
    else $error("retry count not clamped");
  timeout_clamp_a: assert property (cfg_we_in && cfg_in.dto == 8'h00 |=> cfg_out.dto == 8'h01)
    else $error("timeout not clamped");
  // Channel must have read clear through the two-flop synchroniser
  prompt_send_a: assert property (tx_req_in && !tx_busy_out && cfg_out.be == 2'h0 && cca_clear_in
    && $past(cca_clear_in) && $past(cca_clear_in, 2) |-> ##4 mac_send_out) else $error("send late");
  ack_flag_a: assert property (tx_req_in && !tx_busy_out && !cfg_out.retry |=> !ack_request_out)
    else $error("stray ack flag");
  sent_timeout_a: assert property (disc_req_out |-> disc_timeout_out == cfg_out.dto)
    else $error("timeout not sent");
  exit_ok_a: assert property (cmd_mode_exit_out |-> resp_valid_out && resp_ok_out)
    else $error("exit without success");
  empty_name_a: assert property (resolve_node_name_in && !disc_busy_out && name_len_in == 5'h00
    |=> resp_valid_out && !resp_ok_out) else $error("empty name accepted");
  dwell_mask_a: assert property (scan_dwell_out |-> cfg_out.mask[scan_channel_out - 5'h0B])
    else $error("dwell on masked channel");
endmodule // mrsd_top_properties
bind mrsd_top mrsd_top_properties chk (.*);
`default_nettype wire

// ### tb/mrsd_mac_model.sv
`timescale 1ns/10ps
`default_nettype none
module mrsd_mac_model (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // Device side
  input wire logic send_in,
  input wire logic ack_req_in,
  output logic done_out,
  output logic acked_out,
  output logic app_ack_out,
  output logic cca_out,
  output logic [7:0] sends_out
);
  logic [5:0] pipe_ff; // Send history, one bit a cycle
  // Frames finish three cycles after the send
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      pipe_ff <= 6'h00;
      sends_out <= 8'h00;
    end else begin
      pipe_ff <= {pipe_ff[4:0], send_in};
      sends_out <= sends_out + {7'h00, send_in};
    end
  end
  assign done_out = pipe_ff[2];
  assign acked_out = pipe_ff[2];
  // Receiver acks whenever asked, whatever its own retry setting
  assign app_ack_out = pipe_ff[5] & ack_req_in;
  assign cca_out = 1'b1;
endmodule // mrsd_mac_model
`default_nettype wire

// ### tb/mrsd_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module mrsd_tb_top
  import mrsd_pkg::*;
;
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic cfg_we_in, tx_req_in, discover_nodes_in, resolve_node_name_in, reply_valid_in, active_scan_cmd_in;
  logic energy_scan_cmd_in, tx_bcast_in, tx_purged_in, assoc_start_in, coord_start_in, cca_clear_in;
  logic mac_done_in, mac_acked_in, app_ack_in, tx_busy_out, tx_done_out, tx_ok_out, mac_send_out;
  logic ack_request_out, disc_req_out, disc_named_out, report_valid_out, disc_busy_out, disc_done_out;
  logic resp_valid_out, resp_ok_out, cmd_mode_exit_out, scan_busy_out, scan_energy_out, scan_dwell_out;
  logic scan_done_out, s_bc;
  logic [6:0] pv;
  logic [7:0] frame_type_in, disc_timeout_out, resp_frame_type_out, mac_sends, sends, s_ft;
  logic [4:0] name_len_in, scan_channel_out, s_nl;
  logic [31:0] dest_addr_high_out, dest_addr_low_out;
  mrsd_cfg_type cfg_in, cfg_out, s_cfg;
  mrsd_reply_type self_in, reply_in, s_rp;
  mrsd_report_type report_out;
  int n_mismatch = 0, checks_done = 0, cyc = 0, t0;
  // Strobes: settings, transmit, discover, resolve, reply, active scan, energy scan
  assign {cfg_we_in, tx_req_in, discover_nodes_in, resolve_node_name_in, reply_valid_in, active_scan_cmd_in,
    energy_scan_cmd_in} = pv;
  wire [4:0] ev = {scan_done_out, report_valid_out, resp_valid_out, disc_done_out, tx_done_out};
  always #2 clock_in = ~clock_in;
  always @(posedge clock_in) cyc <= cyc + 1;
  // Short tick keeps the millisecond windows inside the run budget
  mrsd_top #(.TICK_CYCLES(2)) uut (.*);
  mrsd_mac_model mac (.clock_in(clock_in), .rst_in(rst_in), .send_in(mac_send_out), .ack_req_in(ack_request_out),
    .done_out(mac_done_in), .acked_out(mac_acked_in), .app_ack_out(app_ack_in), .cca_out(cca_clear_in),
    .sends_out(mac_sends));
  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic stop_test();
    if (n_mismatch == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Qualifiers move with the strobe so they are stable when it is taken
  task automatic pulse(input logic [6:0] p);
    @(posedge clock_in);
    pv <= p;
    cfg_in <= s_cfg;
    tx_bcast_in <= s_bc;
    frame_type_in <= s_ft;
    name_len_in <= s_nl;
    reply_in <= s_rp;
    @(posedge clock_in);
    pv <= 7'h00;
  endtask
  task automatic wait_on(input int sel, input int lim, input logic must);
    for (int i = 0; i < lim; i++) begin
      #1;
      if (ev[sel] === 1'b1) begin
        if (!must) chk("late report", 1'b1, 1'b0);
        return;
      end
      @(posedge clock_in);
    end
    if (must) begin
      n_mismatch++;
      stop_test();
    end
  endtask
  initial begin
    pv = 7'h00;
    {tx_bcast_in, tx_purged_in, assoc_start_in, coord_start_in, s_bc, frame_type_in, s_ft, name_len_in, s_nl} = 31'h0;
    cfg_in = CFG_RST;
    s_cfg = CFG_RST;
    reply_in = '0;
    s_rp = '{64'h0, 16'h1234, 8'hD8};
    self_in = '{64'h00000000000000A5, 16'hFFFF, 8'h00};
    repeat (6) @(posedge clock_in);
    rst_in <= 1'b0;
    #1;
    chk("cfg_out", cfg_out, CFG_RST);
    chk("channel", scan_channel_out, 5'h0B);
    s_cfg.retry = 3'h7;
    s_cfg.dto = 8'h00;
    pulse(7'h40);
    #1;
    chk("retry", cfg_out.retry, 3'h6);
    chk("dto", cfg_out.dto, 8'h01);
    s_cfg.opts = 8'h02;
    // Unicast and broadcast, each without and with app retries
    for (int i = 0; i < 4; i++) begin
      s_cfg.retry = i[0] ? 3'h2 : 3'h0;
      s_bc = i[1];
      pulse(7'h40);
      sends = mac_sends;
      pulse(7'h20);
      wait_on(0, 5000, 1'b1);
      chk("tx_ok_out", tx_ok_out, 1'b1);
      chk("mac sends", mac_sends - sends, (i == 3) ? 8'h04 : 8'h01);
    end
    pulse(7'h10);
    wait_on(3, 4, 1'b1);
    chk("self entry", report_out.low, 32'h000000A5);
    chk("timeout", disc_timeout_out, 8'h01);
    pulse(7'h04);
    wait_on(3, 4, 1'b1);
    chk("strength", report_out.strength, 8'h28);
    chk("short form", {report_out.high, report_out.low}, 64'h1234);
    wait_on(1, 30000, 1'b1);
    pulse(7'h04);
    wait_on(3, 4, 1'b0);
    s_nl = 5'h04;
    pulse(7'h08);
    pulse(7'h04);
    wait_on(2, 4, 1'b1);
    chk("resolve ok", resp_ok_out, 1'b1);
    chk("exit", cmd_mode_exit_out, 1'b1);
    chk("named", disc_named_out, 1'b1);
    @(posedge clock_in);
    #1;
    chk("dest", {dest_addr_high_out, dest_addr_low_out}, 64'h1234);
    s_nl = 5'h00;
    s_ft = 8'h08;
    pulse(7'h08);
    wait_on(2, 4, 1'b1);
    chk("empty name", resp_ok_out, 1'b0);
    chk("resp type", resp_frame_type_out, 8'h88);
    s_cfg.mask = 16'h0006;
    s_cfg.sd = 4'h0;
    pulse(7'h40);
    // Two enabled channels at exponent zero, active then energy
    for (int k = 0; k < 2; k++) begin
      pulse(k ? 7'h01 : 7'h02);
      t0 = cyc;
      wait_on(4, 8000, 1'b1);
      chk("scan time", (cyc - t0) >= 6138 && (cyc - t0) < 6200, 1'b1);
    end
    stop_test();
  end
endmodule // mrsd_tb_top
`default_nettype wire
